// >>> common/rtc_consts.svh
// Named constants for the logger clock, alarm and configuration register page
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// Timing
`define SECOND_NS 1000000000
`define CLK_PERIOD_NS 8
`define PRESCALE_W 27

// Bus geometry: byte address is four times the printed register index
`define ADDR_W 12
`define IDX_W 10
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

// Register indices as printed
`define IDX_SECONDS 10'h200
`define IDX_MINUTES 10'h201
`define IDX_HOURS 10'h202
`define IDX_WEEKDAY 10'h203
`define IDX_DATE 10'h204
`define IDX_MONTH 10'h205
`define IDX_YEAR 10'h206
`define IDX_AL_SECONDS 10'h207
`define IDX_AL_MINUTES 10'h208
`define IDX_AL_HOURS 10'h209
`define IDX_AL_WEEKDAY 10'h20a
`define IDX_TEMP_LOW 10'h20b
`define IDX_TEMP_HIGH 10'h20c
`define IDX_SAMPLE 10'h20d
`define IDX_CONTROL 10'h20e
`define IDX_SPARE0 10'h20f
`define IDX_SPARE1 10'h210
`define IDX_TEMP_READ 10'h211
`define IDX_STATUS 10'h214

// Page slots (index minus page base)
`define PAGE_LAST 14
`define SLOT_W 4
`define SLOT_SECONDS 4'h0
`define SLOT_MINUTES 4'h1
`define SLOT_HOURS 4'h2
`define SLOT_WEEKDAY 4'h3
`define SLOT_DATE 4'h4
`define SLOT_MONTH 4'h5
`define SLOT_YEAR 4'h6
`define SLOT_AL_SECONDS 4'h7
`define SLOT_AL_MINUTES 4'h8
`define SLOT_AL_HOURS 4'h9
`define SLOT_AL_WEEKDAY 4'ha
`define SLOT_TEMP_LOW 4'hb
`define SLOT_TEMP_HIGH 4'hc
`define SLOT_SAMPLE 4'hd
`define SLOT_CONTROL 4'he

// Writable bit masks; fixed-zero bits are cleared on write
`define WMASK_TIME 8'h7f
`define WMASK_WEEKDAY 8'h07
`define WMASK_DATE 8'h3f
`define WMASK_MONTH 8'h9f
`define WMASK_FULL 8'hff
`define WMASK_AL_WEEKDAY 8'h87
`define WMASK_CONTROL 8'hdf

// Field positions
`define HOUR_MODE12_BIT 6
`define HOUR_PM_BIT 5
`define ALARM_MASK_BIT 7
`define CENTURY_BIT 7
`define CTRL_OSC_OFF_BIT 7
`define CTRL_MISSION_N_BIT 4
`define CTRL_LOW_SRCH_BIT 2
`define CTRL_HIGH_SRCH_BIT 1
`define CTRL_TIMER_SRCH_BIT 0
`define ST_MEMORY_CLEARED_FLAG_BIT 6
`define ST_MIP_BIT 5
`define ST_TLF_BIT 2
`define ST_THF_BIT 1
`define ST_TAF_BIT 0

// BCD limits
`define BCD_ZERO 8'h00
`define BCD_ONE 8'h01
`define BCD_NINE 4'h9
`define BCD_59 8'h59
`define BCD_23 6'h23
`define BCD_11 5'h11
`define BCD_12 5'h12
`define BCD_10 5'h10
`define BCD_7 8'h07
`define BCD_99 8'h99
`define BCD_FEB 8'h02
`define BCD_APR 8'h04
`define BCD_JUN 8'h06
`define BCD_SEP 8'h09
`define BCD_NOV 8'h11
`define BCD_DAYS28 8'h28
`define BCD_DAYS29 8'h29
`define BCD_DAYS30 8'h30
`define BCD_DAYS31 8'h31
`define BCD_U0 4'h0
`define BCD_U2 4'h2
`define BCD_U4 4'h4
`define BCD_U6 4'h6
`define BCD_U8 4'h8

// Temperature codes
`define TEMP_RAW_W 11
`define TEMP_CODE_MIN 11'sh001
`define TEMP_CODE_MAX 11'sh0fe
`define TEMP_UNDER 8'h00
`define TEMP_OVER 8'hff
`define BIN_MSB 7
`define BIN_LSB 2

`endif

// >>> common/rtc_pkg.sv
// Types shared by the logger register page
`include "rtc_consts.svh"
package rtc_pkg;

  typedef struct packed {
    logic [`PAGE_LAST:0][7:0] page;
    logic [`PRESCALE_W-1:0] prescale;
    logic [7:0] temp_code;
    logic [5:0] temp_bin;
    logic memory_cleared_flag;
    logic mission_active;
    logic low_temp_flag;
    logic high_temp_flag;
    logic timer_alarm_flag;
    logic aw_got;
    logic w_got;
    logic [`ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wlane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic search_match;
    logic osc_running;
  } rtc_state_type;

  typedef struct packed {
    logic valid;
    logic signed [`TEMP_RAW_W-1:0] raw;
  } temp_result_type;

endpackage

// >>> verilog/logger_rtc_regs.sv
// Logger clock, calendar, alarm and configuration register page behind AXI4-Lite
//
// How it works
// - Hours bit 6 selects 12-hour counting.
// - Hours bit 5 is PM or twenty-hour digit.
// - Weekday counter cycles one through seven.
// - February 29 when year is multiple of four.
// - Century flag toggles on year 99 to 00.
// - Four alarm registers, top bit masks field.
// - Mask bits choose the alarm rate.
// - No masks: weekly alarm on full match.
// - Any clock alarm sets timer alarm flag.
// - Enabled alarm conditions answer conditional search.
// - Temperature is one byte, eighth-degree steps.
// - Out-of-range conversions stored as 00 or FF.
// - Out-of-range codes land in bins 0, 63.
// - Same code format for log and readout.
// - Low then high threshold as full bytes.
// - Sample interval byte, minutes, one to 255.
// - Nonzero sample write starts a cleared, enabled mission.
// - Control write ends mission, stores new value.
// - Control byte holds oscillator, mission, search bits.
// - Control bit 5 always reads zero.
// - Time, calendar and alarm values are BCD.
// - Fixed-zero bits always read zero.
// - Protected write during mission ends the mission.
// - Oscillator disable stops the clock.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"

module logger_rtc_regs
  import rtc_pkg::*;
#(
  parameter int unsigned second_cycles = `SECOND_NS / `CLK_PERIOD_NS
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter result and memory-clear event
  input wire temp_result_type temp_result,
  input wire logic memory_clear_done,
  // Status to the rest of the logger
  output logic mission_active,
  output logic search_match,
  output logic osc_running,
  output logic [7:0] temp_code,
  output logic [5:0] temp_bin
);

  localparam logic [`PRESCALE_W-1:0] prescale_last = `PRESCALE_W'(second_cycles - 1);

  rtc_state_type s;
  rtc_state_type next_s;

  // BCD increment with wrap: returns {wrapped, value}
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                           input logic [7:0] first);
    logic [8:0] r;
    r = {1'b0, v};
    if (v == last)
      r = {1'b1, first};
    else if (v[3:0] == `BCD_NINE)
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction

  // Hours advance in either mode: returns {day carry, hours byte}
  function automatic logic [8:0] hour_step(input logic [7:0] h);
    logic [7:0] r;
    logic c;
    r = h;
    c = 1'b0;
    if (h[`HOUR_MODE12_BIT])
    begin
      if (h[4:0] == `BCD_12)
        r[4:0] = 5'h01;
      else if (h[4:0] == `BCD_11)
      begin
        r[4:0] = `BCD_12;
        r[`HOUR_PM_BIT] = ~h[`HOUR_PM_BIT];
        c = h[`HOUR_PM_BIT];
      end
      else if (h[3:0] == `BCD_NINE)
        r[4:0] = `BCD_10;
      else
        r[3:0] = h[3:0] + 4'h1;
    end
    else
    begin
      // Bit 5 acts as the twenty-hour digit here
      if (h[5:0] == `BCD_23)
      begin
        r[5:0] = 6'h00;
        c = 1'b1;
      end
      else if (h[3:0] == `BCD_NINE)
        r[5:0] = {h[5:4] + 2'h1, 4'h0};
      else
        r[3:0] = h[3:0] + 4'h1;
    end
    return {c, r};
  endfunction

  // Last date of a month; leap test on the BCD year digits
  function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    logic [7:0] d;
    // Tens digit even: units 0,4,8; odd: units 2,6. Year 00 counts as leap.
    leap = (!y[4] && (y[3:0] == `BCD_U0 || y[3:0] == `BCD_U4 || y[3:0] == `BCD_U8)) ||
           (y[4] && (y[3:0] == `BCD_U2 || y[3:0] == `BCD_U6));
    case (m)
      `BCD_FEB: d = leap ? `BCD_DAYS29 : `BCD_DAYS28;
      `BCD_APR, `BCD_JUN, `BCD_SEP, `BCD_NOV: d = `BCD_DAYS30;
      default: d = `BCD_DAYS31;
    endcase
    return d;
  endfunction

  // Writable bits of each page slot; decoded on every write
  function automatic logic [7:0] write_mask(input logic [`SLOT_W-1:0] slot);
    logic [7:0] m;
    case (slot)
      `SLOT_SECONDS, `SLOT_MINUTES, `SLOT_HOURS: m = `WMASK_TIME;
      `SLOT_WEEKDAY: m = `WMASK_WEEKDAY;
      `SLOT_DATE: m = `WMASK_DATE;
      `SLOT_MONTH: m = `WMASK_MONTH;
      `SLOT_AL_WEEKDAY: m = `WMASK_AL_WEEKDAY;
      `SLOT_CONTROL: m = `WMASK_CONTROL;
      default: m = `WMASK_FULL;
    endcase
    return m;
  endfunction

  // Address decode shared by the read and write paths
  function automatic logic addr_mapped(input logic [`ADDR_W-1:0] a);
    logic [`IDX_W-1:0] idx;
    idx = a[`ADDR_W-1:2];
    return (a[1:0] == 2'h0) &&
           ((idx >= `IDX_SECONDS && idx <= `IDX_TEMP_READ) || idx == `IDX_STATUS);
  endfunction

  // Next state
  always_comb
  begin
    logic [`IDX_W-1:0] widx;
    logic [`IDX_W-1:0] ridx;
    logic [`SLOT_W-1:0] wslot;
    logic [8:0] step;
    logic carry;
    logic tick;
    logic alarm_hit;
    logic signed [`TEMP_RAW_W-1:0] raw;
    logic [7:0] code;
    logic [7:0] ctrl;
    widx = s.awaddr[`ADDR_W-1:2];
    ridx = s_axi_araddr[`ADDR_W-1:2];
    wslot = widx[`SLOT_W-1:0];
    step = 9'h000;
    carry = 1'b0;
    alarm_hit = 1'b0;
    raw = temp_result.raw;
    code = raw[7:0];
    ctrl = s.page[`SLOT_CONTROL];
    tick = !ctrl[`CTRL_OSC_OFF_BIT] && (s.prescale == prescale_last);
    next_s = s;

    // Seconds prescaler, frozen while the oscillator is off
    if (ctrl[`CTRL_OSC_OFF_BIT])
      next_s.prescale = s.prescale;
    else if (tick)
      next_s.prescale = '0;
    else
      next_s.prescale = s.prescale + `PRESCALE_W'(1);

    // Calendar ripple, all fields in BCD
    if (tick)
    begin
      step = bcd_step(s.page[`SLOT_SECONDS], `BCD_59, `BCD_ZERO);
      next_s.page[`SLOT_SECONDS] = step[7:0];
      carry = step[8];
      if (carry)
      begin
        step = bcd_step(s.page[`SLOT_MINUTES], `BCD_59, `BCD_ZERO);
        next_s.page[`SLOT_MINUTES] = step[7:0];
        carry = step[8];
      end
      if (carry)
      begin
        step = hour_step(s.page[`SLOT_HOURS]);
        next_s.page[`SLOT_HOURS] = step[7:0];
        carry = step[8];
      end
      if (carry)
      begin
        step = bcd_step(s.page[`SLOT_WEEKDAY], `BCD_7, `BCD_ONE);
        next_s.page[`SLOT_WEEKDAY] = step[7:0];
        step = bcd_step(s.page[`SLOT_DATE],
                        month_last({3'h0, s.page[`SLOT_MONTH][4:0]}, s.page[`SLOT_YEAR]),
                        `BCD_ONE);
        next_s.page[`SLOT_DATE] = step[7:0];
        carry = step[8];
      end
      if (carry)
      begin
        step = bcd_step({3'h0, s.page[`SLOT_MONTH][4:0]}, {3'h0, `BCD_12}, `BCD_ONE);
        next_s.page[`SLOT_MONTH][4:0] = step[4:0];
        carry = step[8];
      end
      if (carry)
      begin
        step = bcd_step(s.page[`SLOT_YEAR], `BCD_99, `BCD_ZERO);
        next_s.page[`SLOT_YEAR] = step[7:0];
        if (step[8])
          next_s.page[`SLOT_MONTH][`CENTURY_BIT] = ~s.page[`SLOT_MONTH][`CENTURY_BIT];
      end
      // Each unmasked field must match the freshly advanced time
      alarm_hit =
        (s.page[`SLOT_AL_SECONDS][`ALARM_MASK_BIT] ||
         next_s.page[`SLOT_SECONDS][6:0] == s.page[`SLOT_AL_SECONDS][6:0]) &&
        (s.page[`SLOT_AL_MINUTES][`ALARM_MASK_BIT] ||
         next_s.page[`SLOT_MINUTES][6:0] == s.page[`SLOT_AL_MINUTES][6:0]) &&
        (s.page[`SLOT_AL_HOURS][`ALARM_MASK_BIT] ||
         next_s.page[`SLOT_HOURS][6:0] == s.page[`SLOT_AL_HOURS][6:0]) &&
        (s.page[`SLOT_AL_WEEKDAY][`ALARM_MASK_BIT] ||
         next_s.page[`SLOT_WEEKDAY][2:0] == s.page[`SLOT_AL_WEEKDAY][2:0]);
    end

    // Write channel capture, address and data in either order
    if (s.awready && s_axi_awvalid)
    begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata[7:0];
      next_s.wlane0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;

    // Register write; a write with lane 0 off is answered but stores nothing
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = addr_mapped(s.awaddr) ? `AXI_OKAY : `AXI_SLVERR;
      if (addr_mapped(s.awaddr) && s.wlane0)
      begin
        if (widx == `IDX_STATUS)
        begin
          // Only mission and alarm flags can be written, and only to zero
          if (!s.wdata[`ST_MIP_BIT])
            next_s.mission_active = 1'b0;
          if (!s.wdata[`ST_TLF_BIT])
            next_s.low_temp_flag = 1'b0;
          if (!s.wdata[`ST_THF_BIT])
            next_s.high_temp_flag = 1'b0;
          if (!s.wdata[`ST_TAF_BIT])
            next_s.timer_alarm_flag = 1'b0;
        end
        else
        begin
          // Any other page write, read-only ones included, stops a mission
          next_s.mission_active = 1'b0;
          if (widx <= `IDX_CONTROL)
            next_s.page[wslot] = s.wdata & write_mask(wslot);
          if (widx == `IDX_SAMPLE && s.wdata != 8'h00 && s.memory_cleared_flag &&
              !ctrl[`CTRL_MISSION_N_BIT] && !s.mission_active)
          begin
            next_s.mission_active = 1'b1;
            next_s.memory_cleared_flag = 1'b0;
          end
        end
      end
    end

    // Read channel; one read in flight, answered the cycle after acceptance
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (s.arready && s_axi_arvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = addr_mapped(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
      next_s.rdata = 8'h00;
      if (addr_mapped(s_axi_araddr))
      begin
        if (ridx <= `IDX_CONTROL)
          next_s.rdata = s.page[ridx[`SLOT_W-1:0]];
        else if (ridx == `IDX_TEMP_READ)
          next_s.rdata = s.temp_code;
        else if (ridx == `IDX_STATUS)
        begin
          next_s.rdata[`ST_MEMORY_CLEARED_FLAG_BIT] = s.memory_cleared_flag;
          next_s.rdata[`ST_MIP_BIT] = s.mission_active;
          next_s.rdata[`ST_TLF_BIT] = s.low_temp_flag;
          next_s.rdata[`ST_THF_BIT] = s.high_temp_flag;
          next_s.rdata[`ST_TAF_BIT] = s.timer_alarm_flag;
        end
      end
    end

    // Temperature code: clamp out-of-range results to the reserved codes
    if (temp_result.valid)
    begin
      if (raw < `TEMP_CODE_MIN)
        code = `TEMP_UNDER;
      else if (raw > `TEMP_CODE_MAX)
        code = `TEMP_OVER;
      next_s.temp_code = code;
      next_s.temp_bin = code[`BIN_MSB:`BIN_LSB];
      if (s.mission_active && code <= s.page[`SLOT_TEMP_LOW])
        next_s.low_temp_flag = 1'b1;
      if (s.mission_active && code >= s.page[`SLOT_TEMP_HIGH])
        next_s.high_temp_flag = 1'b1;
    end

    // Events after software clears: a same-cycle set wins
    if (alarm_hit)
      next_s.timer_alarm_flag = 1'b1;
    if (memory_clear_done)
      next_s.memory_cleared_flag = 1'b1;

    // Ready flags and registered status outputs
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
    ctrl = next_s.page[`SLOT_CONTROL];
    next_s.search_match = (ctrl[`CTRL_TIMER_SRCH_BIT] && next_s.timer_alarm_flag) ||
                          (ctrl[`CTRL_HIGH_SRCH_BIT] && next_s.high_temp_flag) ||
                          (ctrl[`CTRL_LOW_SRCH_BIT] && next_s.low_temp_flag);
    next_s.osc_running = !ctrl[`CTRL_OSC_OFF_BIT];

    // Synchronous reset: midnight, 24-hour mode, weekday 1, 1 January
    if (!aresetn)
    begin
      next_s = '0;
      next_s.page[`SLOT_WEEKDAY] = `BCD_ONE;
      next_s.page[`SLOT_DATE] = `BCD_ONE;
      next_s.page[`SLOT_MONTH] = `BCD_ONE;
      next_s.osc_running = 1'b1;
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    s <= next_s;
  end

  // Outputs straight from the state flops
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = {24'h000000, s.rdata};
  assign s_axi_rresp = s.rresp;
  assign mission_active = s.mission_active;
  assign search_match = s.search_match;
  assign osc_running = s.osc_running;
  assign temp_code = s.temp_code;
  assign temp_bin = s.temp_bin;

endmodule
`default_nettype wire

// >>> verif/rtc_regs_properties.sv
// Port checks for the register page
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"
module rtc_regs_properties
  import rtc_pkg::*;
(
  // Clock, reset and register bus
  input wire logic aclk, aresetn,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr, s_axi_araddr,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic [31:0] s_axi_wdata, s_axi_rdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  // Converter side and status
  input wire temp_result_type temp_result,
  input wire logic memory_clear_done, mission_active, search_match, osc_running,
  input wire logic [7:0] temp_code,
  input wire logic [5:0] temp_bin
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Bus events
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ctrl_write;
    write_taken ##0 (s_axi_awaddr == 12'h838 && s_axi_wstrb[0]);
  endsequence
  sequence ctrl_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h838;
  endsequence

  a_write_answer: assert property (write_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_osc_control: assert property (ctrl_write |-> ##2 osc_running == !$past(s_axi_wdata[7], 2))
    else $error("oscillator ignores control bit 7");
  a_mission_stop: assert property (ctrl_write |-> ##2 !mission_active)
    else $error("mission survived control write");
  a_bit5_zero: assert property (ctrl_read |=> s_axi_rdata[5] == 1'b0)
    else $error("control bit 5 read as one");
  a_temp_under: assert property (temp_result.valid && temp_result.raw < 1 |=> temp_code == 8'h00 && temp_bin == 6'h00)
    else $error("low result not clamped");
  a_temp_over: assert property (temp_result.valid && temp_result.raw > 254 |=> temp_code == 8'hff && temp_bin == 6'h3f)
    else $error("high result not clamped");
  a_temp_pass: assert property (temp_result.valid && temp_result.raw > 0 && temp_result.raw < 255 |=> temp_code == $past(temp_result.raw[7:0]))
    else $error("valid code altered");
endmodule
`default_nettype wire

// >>> verif/axi_host_model.sv
// AXI4-Lite master model for single register transfers
`timescale 1ns/1ps
`default_nettype none
module axi_host_model
(
  // Clock
  input wire logic aclk,
  // Write side
  output logic [11:0] s_axi_awaddr,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready,
  input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  // Read side
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid, s_axi_rready,
  input wire logic s_axi_arready, s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  // Quiet bus at time zero
  initial
  begin
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // AW and W offered together, each dropped once taken; released payload inverted
  task automatic bus_write(input logic [9:0] idx, input logic [7:0] data,
    output logic [1:0] resp);
    logic aw_done = 1'b0;
    logic w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= 32'(data);
    s_axi_wstrb <= 4'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    forever
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~{idx, 2'b00};
      end
      if (!w_done && s_axi_wready)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~32'(data);
      end
      if (s_axi_bvalid)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
  endtask

  // Address held until taken, data taken where rvalid is seen
  task automatic bus_read(input logic [9:0] idx, output logic [31:0] data,
    output logic [1:0] resp);
    logic ar_done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    forever
    begin
      @(posedge aclk);
      if (!ar_done && s_axi_arready)
      begin
        ar_done = 1'b1;
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~{idx, 2'b00};
      end
      if (s_axi_rvalid)
      begin
        data = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the logger register page
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"
module tb_top
  import rtc_pkg::*;
;
  logic aclk, aresetn, memory_clear_done;
  logic [`ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic mission_active, search_match, osc_running;
  logic [7:0] temp_code;
  logic [5:0] temp_bin;
  temp_result_type temp_result;
  int failures, total_checks, cycles;
  // Register rows: index, byte written, byte read back
  logic [27:0] reg_rows [10] = '{28'h202ff7f, 28'h203ff07, 28'h204ff3f, 28'h205ff9f,
    28'h20aff87, 28'h207ffff, 28'h20b4444, 28'h20ce4e4, 28'h20dffff, 28'h20effdf};
  // Calendar rows, year first: start and a second later
  logic [55:0] cal_start [5] = '{56'h04822807235959, 56'h01022803235959,
    56'h99123101235959, 56'h10061505715959, 56'h10061505195959};
  logic [55:0] cal_end [5] = '{56'h04822901000000, 56'h01030104000000,
    56'h00810102000000, 56'h10061606520000, 56'h10061505200000};
  // Converter rows: raw result and stored code
  logic signed [10:0] temp_raw [7] = '{-11'sd3, 11'sd0, 11'sd1, 11'sd68, 11'sd254, 11'sd255,
    11'sd600};
  logic [7:0] temp_exp [7] = '{8'h00, 8'h00, 8'h01, 8'h44, 8'hfe, 8'hff, 8'hff};

  // Short second keeps the run brief
  logger_rtc_regs #(.second_cycles(20)) u_logger_rtc_regs (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .temp_result, .memory_clear_done,
    .mission_active, .search_match, .osc_running, .temp_code, .temp_bin);
  axi_host_model u_axi_host_model (.aclk, .s_axi_awaddr, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_awvalid, .s_axi_wvalid, .s_axi_bready, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_rready, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rdata, .s_axi_rresp);

  // Clock and hang guard
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end

  // Checks, bus helpers, verdict
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] data);
    logic [1:0] resp;
    u_axi_host_model.bus_write(idx, data, resp);
    check("write response", 32'(resp), 32'h0);
  endtask
  task automatic rd_check(input string name, input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] data;
    logic [1:0] resp;
    u_axi_host_model.bus_read(idx, data, resp);
    check(name, data, 32'(exp));
  endtask
  task automatic wait_seconds(input logic [7:0] target);
    logic [31:0] data;
    logic [1:0] resp;
    data = '1;
    for (int n = 0; n < 100 && data !== 32'(target); n++)
      u_axi_host_model.bus_read(10'h200, data, resp);
    check("seconds", data, 32'(target));
  endtask
  task automatic end_of_test();
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    logic [31:0] data;
    logic [1:0] resp;
    aresetn = 1'b0;
    memory_clear_done = 1'b0;
    temp_result = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    wr(10'h20e, 8'h80);
    foreach (reg_rows[i])
    begin
      wr(reg_rows[i][25:16], reg_rows[i][15:8]);
      rd_check("reg", reg_rows[i][25:16], reg_rows[i][7:0]);
    end
    for (int c = 0; c < 5; c++)
    begin
      wr(10'h20e, 8'h80);
      for (int b = 0; b < 7; b++)
        wr(10'h200 + 10'(b), cal_start[c][b*8 +: 8]);
      wr(10'h20e, 8'h00);
      wait_seconds(8'h00);
      for (int b = 0; b < 7; b++)
        rd_check("cal", 10'h200 + 10'(b), cal_end[c][b*8 +: 8]);
    end
    foreach (temp_raw[i])
    begin
      @(posedge aclk);
      temp_result <= '{valid: 1'b1, raw: temp_raw[i]};
      @(posedge aclk);
      temp_result.valid <= 1'b0;
      @(posedge aclk);
      check("temp code", 32'(temp_code), 32'(temp_exp[i]));
      check("temp bin", 32'(temp_bin), 32'(temp_exp[i][7:2]));
    end
    // Unmapped index
    u_axi_host_model.bus_read(10'h212, data, resp);
    check("unmapped resp", 32'(resp), 32'h2);
    check("unmapped data", data, 32'h0);
    // Seconds-only alarm, then weekly
    wr(10'h20e, 8'h80);
    wr(10'h200, 8'h00);
    wr(10'h207, 8'h03);
    wr(10'h208, 8'h80);
    wr(10'h209, 8'h80);
    wr(10'h20a, 8'h80);
    wr(10'h214, 8'h00);
    wr(10'h20e, 8'h01);
    wait_seconds(8'h02);
    rd_check("alarm early", 10'h214, 8'h00);
    check("search early", 32'(search_match), 32'h0);
    wait_seconds(8'h03);
    rd_check("alarm", 10'h214, 8'h01);
    check("search", 32'(search_match), 32'h1);
    wr(10'h20e, 8'h80);
    wr(10'h207, 8'h05);
    wr(10'h208, 8'h00);
    wr(10'h209, 8'h20);
    wr(10'h20a, 8'h05);
    wr(10'h214, 8'h00);
    wr(10'h20e, 8'h00);
    wait_seconds(8'h05);
    rd_check("weekly", 10'h214, 8'h01);
    // Mission start, then a control write ends it
    @(posedge aclk);
    memory_clear_done <= 1'b1;
    @(posedge aclk);
    memory_clear_done <= 1'b0;
    wr(10'h20d, 8'h00);
    check("mission idle", 32'(mission_active), 32'h0);
    wr(10'h20d, 8'h05);
    check("mission run", 32'(mission_active), 32'h1);
    rd_check("status", 10'h214, 8'h21);
    wr(10'h20e, 8'h88);
    check("mission end", 32'(mission_active), 32'h0);
    rd_check("control", 10'h20e, 8'h88);
    check("osc off", 32'(osc_running), 32'h0);
    // Reset in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    check("osc reset", 32'(osc_running), 32'h1);
    rd_check("control reset", 10'h20e, 8'h00);
    rd_check("date reset", 10'h204, 8'h01);
    end_of_test();
  end
endmodule

bind logger_rtc_regs rtc_regs_properties u_rtc_regs_properties (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_araddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
  .s_axi_rdata, .s_axi_wstrb, .s_axi_bresp, .s_axi_rresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .temp_result,
  .memory_clear_done, .mission_active, .search_match, .osc_running, .temp_code, .temp_bin);
`default_nettype wire
